// ---- core/lbt_pkg.sv ----
package lbt_pkg;

	localparam int unsigned BYTE_W = 8;
	localparam int unsigned WB_ADR_W = 4;
	localparam int unsigned WB_DAT_W = 32;

	// register byte offsets
	localparam logic [WB_ADR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [WB_ADR_W-1:0] STATUS_OFS = 4'h4;

	// control register fields
	localparam int unsigned CTRL_RELEASE_BIT = 0;
	localparam logic CTRL_RELEASE_RST = 1'b0;

	// status register fields
	localparam int unsigned STAT_AB_LSB = 0;
	localparam int unsigned STAT_BA_LSB = 8;
	localparam int unsigned STAT_DIR_BIT = 16;
	localparam int unsigned STAT_BYTE_OE_BIT = 17;
	localparam int unsigned STAT_TRANSP_BIT = 18;
	localparam int unsigned STAT_RELEASE_BIT = 19;

	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic [WB_DAT_W-1:0] RDATA_NONE = 32'h00000000;

	typedef struct packed {
		logic [WB_ADR_W-1:0] adr;
		logic [WB_DAT_W-1:0] dat;
		logic [3:0] sel;
		logic we;
	} lbt_wb_req_t;

	typedef struct packed {
		logic released;
		logic transparent;
		logic byte_oe;
		logic dir_ab;
		logic [BYTE_W-1:0] ba_byte;
		logic [BYTE_W-1:0] ab_byte;
	} lbt_status_t;

endpackage : lbt_pkg

// ---- core/lbt_store.sv ----
`timescale 1ns/100ps
// one direction of the byte path: transparent, latched or edge-clocked storage
module lbt_store (
	input wire logic mclk, // system clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire logic transparency_control, // high: pass through
	input wire logic storage_clock, // direction storage clock, sampled
	input wire logic [lbt_pkg::BYTE_W-1:0] din, // input byte
	output logic [lbt_pkg::BYTE_W-1:0] q // stored or passed byte
);

	logic sclk_prev_q;
	logic [lbt_pkg::BYTE_W-1:0] store_q;
	logic [lbt_pkg::BYTE_W-1:0] store_d;
	wire rise = storage_clock & ~sclk_prev_q;

	// a clock already high when transparency falls gives no edge, so the value holds
	assign store_d = (transparency_control | rise) ? din : store_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_prev_q <= 1'b0;
			store_q <= lbt_pkg::BYTE_RST;
		end else begin
			sclk_prev_q <= storage_clock;
			store_q <= store_d;
		end
	end

	assign q = store_q;

endmodule : lbt_store

// ---- core/lbt_transceiver.sv ----
`timescale 1ns/100ps
// Summary of operation
// - each single-bit backplane line is driven only while its drive enable is high.
// - each single-bit feedback output is driven only while its active-low enable is low.
// - with both enabled, card data drives the line and the line level shows on feedback.
// - a high byte output enable puts both byte ports into high impedance whatever the direction.
// - with the byte enable low, high direction drives the backplane port, low the card port.
// - with transparency high the byte path follows its input without storage.
// - with transparency low and a steady storage clock the stored byte holds.
// - with transparency low a rising storage clock edge captures the input byte.
// - the backplane-to-card direction behaves the same but uses its own storage clock.
// - every data path is non-inverting.
// - while supply is not yet valid all outputs stay in high impedance.
// - undriven card-side byte inputs keep their last level; other inputs have no keeper.
// - a storage clock already high when transparency falls keeps the earlier output.
module lbt_transceiver (
	input wire logic mclk, // system clock, 100 MHz
	input wire logic arst_n, // asynchronous reset, active low
	// classic wishbone slave
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [lbt_pkg::WB_ADR_W-1:0] wb_adr_i, // byte address
	input wire logic [lbt_pkg::WB_DAT_W-1:0] wb_dat_i, // write data
	input wire logic [3:0] wb_sel_i, // byte lanes
	output logic [lbt_pkg::WB_DAT_W-1:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	// byte path controls
	input wire logic byte_output_enable_n, // byte ports disable when high
	input wire logic direction_select, // high: card to backplane
	input wire logic transparency_control, // high: transparent
	input wire logic card_to_backplane_storage_clock, // card-to-backplane capture clock
	input wire logic backplane_to_card_storage_clock, // backplane-to-card capture clock
	// card-side byte port, two-way
	input wire logic [lbt_pkg::BYTE_W-1:0] card_side_byte_port_i, // pin level seen
	input wire logic card_side_byte_port_ext_drv, // card logic drives the pins
	output logic [lbt_pkg::BYTE_W-1:0] card_side_byte_port_o, // drive value
	output logic card_side_byte_port_oe, // drive enable
	// backplane-side byte port, two-way
	input wire logic [lbt_pkg::BYTE_W-1:0] backplane_side_byte_port_i, // pin level seen
	output logic [lbt_pkg::BYTE_W-1:0] backplane_side_byte_port_o, // drive value
	output logic backplane_side_byte_port_oe, // drive enable
	// first single-bit transceiver
	input wire logic first_bit_card_input, // card data
	input wire logic first_bit_drive_enable, // backplane drive enable
	input wire logic first_bit_feedback_output_enable_n, // feedback enable, active low
	input wire logic first_bit_backplane_line_i, // line level seen
	output logic first_bit_backplane_line_o, // line drive value
	output logic first_bit_backplane_line_oe, // line drive enable
	output logic first_bit_feedback_output_o, // feedback value
	output logic first_bit_feedback_output_oe, // feedback drive enable
	// second single-bit transceiver
	input wire logic second_bit_card_input, // card data
	input wire logic second_bit_drive_enable, // backplane drive enable
	input wire logic second_bit_feedback_output_enable_n, // feedback enable, active low
	input wire logic second_bit_backplane_line_i, // line level seen
	output logic second_bit_backplane_line_o, // line drive value
	output logic second_bit_backplane_line_oe, // line drive enable
	output logic second_bit_feedback_output_o, // feedback value
	output logic second_bit_feedback_output_oe // feedback drive enable
);

	// ---------------- register slave ----------------
	lbt_pkg::lbt_wb_req_t req;
	lbt_pkg::lbt_status_t status;
	logic ack_q;
	logic ack_d;
	logic [lbt_pkg::WB_DAT_W-1:0] rdat_q;
	logic [lbt_pkg::WB_DAT_W-1:0] rdat_d;
	logic release_q;
	logic release_d;

	assign req.adr = wb_adr_i;
	assign req.dat = wb_dat_i;
	assign req.sel = wb_sel_i;
	assign req.we = wb_we_i;

	wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire hit_ctrl = req.adr == lbt_pkg::CTRL_OFS;
	wire hit_status = req.adr == lbt_pkg::STATUS_OFS;
	wire wr_ctrl = bus_req & req.we & hit_ctrl & req.sel[0];

	assign ack_d = bus_req;
	// the release bit stands in for a valid supply: until software sets it, nothing drives
	assign release_d = wr_ctrl ? req.dat[lbt_pkg::CTRL_RELEASE_BIT] : release_q;

	wire [lbt_pkg::WB_DAT_W-1:0] ctrl_word =
		{{(lbt_pkg::WB_DAT_W-1){1'b0}}, release_q};
	wire [lbt_pkg::WB_DAT_W-1:0] status_word =
		{{(lbt_pkg::WB_DAT_W-$bits(lbt_pkg::lbt_status_t)){1'b0}}, status};

	// unmapped addresses and writes are acknowledged; unmapped reads return zero
	assign rdat_d = !bus_req || req.we ? lbt_pkg::RDATA_NONE :
		hit_ctrl ? ctrl_word :
		hit_status ? status_word : lbt_pkg::RDATA_NONE;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 1'b0;
			rdat_q <= lbt_pkg::RDATA_NONE;
			release_q <= lbt_pkg::CTRL_RELEASE_RST;
		end else begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			release_q <= release_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ---------------- card-side keeper ----------------
	logic [lbt_pkg::BYTE_W-1:0] keep_q;
	logic [lbt_pkg::BYTE_W-1:0] keep_d;
	logic [lbt_pkg::BYTE_W-1:0] card_byte_in;
	logic card_oe_q;

	// only the card-side byte port has a keeper; backplane and bit inputs are used raw
	// while the device drives the card pins its own value is the level seen, with no lag
	assign card_byte_in = keep_d;
	assign keep_d = card_side_byte_port_ext_drv ? card_side_byte_port_i :
		card_oe_q ? card_side_byte_port_o : keep_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			keep_q <= lbt_pkg::BYTE_RST;
		else
			keep_q <= keep_d;
	end

	// ---------------- byte path storage ----------------
	// both directions store all the time, enables only gate the drivers
	lbt_store u_store_ab (
		.mclk(mclk),
		.arst_n(arst_n),
		.transparency_control(transparency_control),
		.storage_clock(card_to_backplane_storage_clock),
		.din(card_byte_in),
		.q(backplane_side_byte_port_o)
	);

	lbt_store u_store_ba (
		.mclk(mclk),
		.arst_n(arst_n),
		.transparency_control(transparency_control),
		.storage_clock(backplane_to_card_storage_clock),
		.din(backplane_side_byte_port_i),
		.q(card_side_byte_port_o)
	);

	// ---------------- byte enables ----------------
	logic bp_oe_q;
	wire byte_on = ~byte_output_enable_n & release_q;
	wire bp_oe_d = byte_on & direction_select;
	wire card_oe_d = byte_on & ~direction_select;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bp_oe_q <= 1'b0;
			card_oe_q <= 1'b0;
		end else begin
			bp_oe_q <= bp_oe_d;
			card_oe_q <= card_oe_d;
		end
	end

	assign backplane_side_byte_port_oe = bp_oe_q;
	assign card_side_byte_port_oe = card_oe_q;

	// ---------------- single-bit transceivers ----------------
	logic [1:0] line_o_q;
	logic [1:0] line_oe_q;
	logic [1:0] fb_o_q;
	logic [1:0] fb_oe_q;
	wire [1:0] bit_card = {second_bit_card_input, first_bit_card_input};
	wire [1:0] bit_line = {second_bit_backplane_line_i, first_bit_backplane_line_i};
	wire [1:0] bit_drv = {second_bit_drive_enable, first_bit_drive_enable};
	wire [1:0] bit_fb_n = {second_bit_feedback_output_enable_n,
		first_bit_feedback_output_enable_n};
	// tied enables work unchanged: high drives the line, low feeds the line back
	wire [1:0] line_oe_d = bit_drv & {2{release_q}};
	wire [1:0] fb_oe_d = ~bit_fb_n & {2{release_q}};

	// both paths run at once when both are enabled
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			line_o_q <= 2'h0;
			line_oe_q <= 2'h0;
			fb_o_q <= 2'h0;
			fb_oe_q <= 2'h0;
		end else begin
			line_o_q <= bit_card;
			line_oe_q <= line_oe_d;
			fb_o_q <= bit_line;
			fb_oe_q <= fb_oe_d;
		end
	end

	assign first_bit_backplane_line_o = line_o_q[0];
	assign second_bit_backplane_line_o = line_o_q[1];
	assign first_bit_backplane_line_oe = line_oe_q[0];
	assign second_bit_backplane_line_oe = line_oe_q[1];
	assign first_bit_feedback_output_o = fb_o_q[0];
	assign second_bit_feedback_output_o = fb_o_q[1];
	assign first_bit_feedback_output_oe = fb_oe_q[0];
	assign second_bit_feedback_output_oe = fb_oe_q[1];

	// ---------------- status view ----------------
	assign status.released = release_q;
	assign status.transparent = transparency_control;
	assign status.byte_oe = bp_oe_q | card_oe_q;
	assign status.dir_ab = direction_select;
	assign status.ba_byte = card_side_byte_port_o;
	assign status.ab_byte = backplane_side_byte_port_o;

endmodule : lbt_transceiver

// ---- bench/lbt_far_model.sv ----
`timescale 1ns/100ps
// card logic and backplane byte drivers facing the device
module lbt_far_model (
	input wire logic [7:0] card_drv, // card logic value
	input wire logic [7:0] bp_drv, // backplane value
	input wire logic card_side_byte_port_ext_drv, // card logic drives
	input wire logic [7:0] card_side_byte_port_o, // device card value
	input wire logic card_side_byte_port_oe, // device card enable
	input wire logic [7:0] backplane_side_byte_port_o, // device bp value
	input wire logic backplane_side_byte_port_oe, // device bp enable
	output logic [7:0] card_side_byte_port_i, // card pin level
	output logic [7:0] backplane_side_byte_port_i // bp pin level
);
	// an undriven card pin keeps its last driven level
	always_latch begin
		if (card_side_byte_port_ext_drv)
			card_side_byte_port_i <= card_drv;
		else if (card_side_byte_port_oe)
			card_side_byte_port_i <= card_side_byte_port_o;
	end
	// another card drives the backplane byte whenever the device does not
	assign backplane_side_byte_port_i = backplane_side_byte_port_oe ?
		backplane_side_byte_port_o : bp_drv;
endmodule : lbt_far_model

// ---- bench/lbt_chk.sv ----
`timescale 1ns/100ps
module lbt_chk (
	input wire logic mclk, // clock
	input wire logic arst_n, // reset
	input wire logic byte_output_enable_n, // byte enable
	input wire logic direction_select, // direction
	input wire logic transparency_control, // transparent
	input wire logic card_to_backplane_storage_clock, // ab clock
	input wire logic card_side_byte_port_ext_drv, // card drives
	input wire logic [7:0] card_side_byte_port_i, // card pins
	input wire logic [7:0] card_side_byte_port_o, // card value
	input wire logic card_side_byte_port_oe, // card enable
	input wire logic [7:0] backplane_side_byte_port_i, // bp pins
	input wire logic [7:0] backplane_side_byte_port_o, // bp value
	input wire logic backplane_side_byte_port_oe, // bp enable
	input wire logic first_bit_card_input, // bit data
	input wire logic first_bit_drive_enable, // bit enable
	input wire logic first_bit_backplane_line_i, // line level
	input wire logic first_bit_backplane_line_o, // line value
	input wire logic first_bit_backplane_line_oe, // line enable
	input wire logic first_bit_feedback_output_o, // feedback
	input wire logic first_bit_feedback_output_enable_n, // feedback enable
	input wire logic first_bit_feedback_output_oe, // feedback drive
	input wire logic second_bit_card_input, // bit data
	input wire logic second_bit_drive_enable, // bit enable
	input wire logic second_bit_feedback_output_enable_n, // feedback enable
	input wire logic second_bit_backplane_line_o, // line value
	input wire logic second_bit_backplane_line_oe, // line enable
	input wire logic second_bit_feedback_output_oe // feedback drive
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_ab_rise;
		!transparency_control && card_side_byte_port_ext_drv &&
			$rose(card_to_backplane_storage_clock);
	endsequence
	chk_ab_capture: assert property (s_ab_rise |=>
		backplane_side_byte_port_o == $past(card_side_byte_port_i)) else $error("edge missed");
	chk_ab_hold: assert property (!transparency_control &&
		!$rose(card_to_backplane_storage_clock) |=> $stable(backplane_side_byte_port_o))
		else $error("stored byte moved");
	chk_ab_follow: assert property (transparency_control && card_side_byte_port_ext_drv |=>
		backplane_side_byte_port_o == $past(card_side_byte_port_i)) else $error("no follow");
	chk_ba_follow: assert property (transparency_control |=>
		card_side_byte_port_o == $past(backplane_side_byte_port_i)) else $error("ba no follow");
	chk_byte_isolate: assert property (byte_output_enable_n |=>
		!backplane_side_byte_port_oe && !card_side_byte_port_oe) else $error("not isolated");
	chk_dir_select: assert property (backplane_side_byte_port_oe |->
		$past(direction_select) && !card_side_byte_port_oe) else $error("wrong direction");
	chk_bit_drive: assert property (first_bit_backplane_line_oe |->
		$past(first_bit_drive_enable)) else $error("line driven while disabled");
	chk_bit_data: assert property (arst_n |=>
		first_bit_backplane_line_o == $past(first_bit_card_input) &&
		first_bit_feedback_output_o == $past(first_bit_backplane_line_i)) else $error("bit data");
	chk_fb_enable: assert property (first_bit_feedback_output_oe |->
		!$past(first_bit_feedback_output_enable_n)) else $error("feedback driven while disabled");
	chk_bit2_drive: assert property (second_bit_backplane_line_oe |->
		$past(second_bit_drive_enable)) else $error("second line driven while disabled");
	chk_fb2_enable: assert property (second_bit_feedback_output_oe |->
		!$past(second_bit_feedback_output_enable_n)) else $error("second feedback driven");
	chk_bit2_data: assert property (arst_n |=>
		second_bit_backplane_line_o == $past(second_bit_card_input)) else $error("second bit data");
endmodule : lbt_chk
bind lbt_transceiver lbt_chk u_chk (.*);

// ---- bench/tb.sv ----
`timescale 1ns/100ps
module tb;
	logic mclk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rel, cab_p, cba_p;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic byte_output_enable_n, direction_select, transparency_control;
	logic card_to_backplane_storage_clock, backplane_to_card_storage_clock;
	logic [7:0] card_drv, bp_drv, ab_e, ba_e, card_side_byte_port_i, card_side_byte_port_o;
	logic [7:0] backplane_side_byte_port_i, backplane_side_byte_port_o;
	logic card_side_byte_port_ext_drv, card_side_byte_port_oe, backplane_side_byte_port_oe;
	logic first_bit_card_input, first_bit_drive_enable, first_bit_feedback_output_enable_n;
	logic first_bit_backplane_line_i, first_bit_backplane_line_o, first_bit_backplane_line_oe;
	logic first_bit_feedback_output_o, first_bit_feedback_output_oe, second_bit_card_input;
	logic second_bit_drive_enable, second_bit_feedback_output_enable_n;
	logic second_bit_backplane_line_i, second_bit_backplane_line_o, second_bit_backplane_line_oe;
	logic second_bit_feedback_output_o, second_bit_feedback_output_oe;
	int seed = 16284;
	int failures = 0;
	int cmp_count = 0;
	logic [31:0] exp_q[$];
	logic [31:0] cur_r;
	lbt_pkg::lbt_status_t st;
	lbt_transceiver uut (.*);
	lbt_far_model u_far (.*);
	// backplane bit lines carry pull-ups
	assign first_bit_backplane_line_i = first_bit_backplane_line_oe ?
		first_bit_backplane_line_o : 1'b1;
	assign second_bit_backplane_line_i = second_bit_backplane_line_oe ?
		second_bit_backplane_line_o : 1'b1;
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ab_e <= lbt_pkg::BYTE_RST;
			ba_e <= lbt_pkg::BYTE_RST;
			cab_p <= 1'b0;
			cba_p <= 1'b0;
		end else begin
			if (transparency_control || (card_to_backplane_storage_clock && !cab_p))
				ab_e <= card_side_byte_port_i;
			if (transparency_control || (backplane_to_card_storage_clock && !cba_p))
				ba_e <= backplane_side_byte_port_i;
			cab_p <= card_to_backplane_storage_clock;
			cba_p <= backplane_to_card_storage_clock;
		end
	end
	always @(posedge mclk) begin
		if (wb_ack_o && !wb_we_i) begin
			cmp_count++;
			if (exp_q.size() == 0 || wb_dat_o !== exp_q[0]) begin
				failures++;
				$display("wrong value at %0t: read %h", $time, wb_dat_o);
			end
			if (exp_q.size() != 0)
				void'(exp_q.pop_front());
		end
	end
	task automatic drive(input logic [31:0] r);
		cur_r = r;
		byte_output_enable_n <= r[0];
		direction_select <= r[1];
		transparency_control <= r[2] & r[3];
		card_to_backplane_storage_clock <= r[4];
		backplane_to_card_storage_clock <= r[5];
		// card logic stays off the pins whenever the device may drive them
		card_side_byte_port_ext_drv <= (r[1] | r[0]) & ~r[6];
		card_drv <= r[15:8];
		bp_drv <= r[23:16];
		first_bit_card_input <= r[24];
		first_bit_drive_enable <= r[25];
		first_bit_feedback_output_enable_n <= r[26];
		second_bit_card_input <= r[27];
		second_bit_drive_enable <= r[28];
		second_bit_feedback_output_enable_n <= r[28];
	endtask : drive
	task automatic rnd(input int n);
		logic [31:0] r;
		logic [31:0] p;
		// outputs seen at an edge come from the word sampled one edge earlier
		p = cur_r;
		repeat (n) begin
			r = $random(seed);
			drive(r);
			@(posedge mclk);
			cmp_count++;
			if (!rel) begin
				if ((card_side_byte_port_oe | backplane_side_byte_port_oe | first_bit_backplane_line_oe
					| first_bit_feedback_output_oe | second_bit_backplane_line_oe
					| second_bit_feedback_output_oe) !== 1'b0) begin
					failures++;
					$display("wrong value at %0t: driven before release", $time);
				end
			end else if ({second_bit_backplane_line_oe, second_bit_feedback_output_oe,
				second_bit_backplane_line_o, first_bit_backplane_line_oe,
				first_bit_feedback_output_oe, first_bit_backplane_line_o,
				backplane_side_byte_port_oe, card_side_byte_port_oe} !== {p[28], ~p[28], p[27],
				p[25], ~p[26], p[24], ~p[0] & p[1], ~p[0] & ~p[1]}) begin
				failures++;
				$display("wrong value at %0t: bit or byte enables", $time);
			end
			p = r;
		end
	endtask : rnd
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
		input logic [3:0] sel, input logic [31:0] e);
		int n;
		n = 0;
		if (!we)
			exp_q.push_back(e);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		wb_sel_i <= sel;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n == 50) begin
			failures++;
			$display("wrong value at %0t: no ack", $time);
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge mclk);
	endtask : wb
	task automatic chk_status();
		// no load may land while the status word is read
		transparency_control <= 1'b0;
		repeat (3) @(posedge mclk);
		st = '{rel, 1'b0, rel & !byte_output_enable_n, direction_select, ba_e, ab_e};
		wb(1'b0, lbt_pkg::STATUS_OFS, 32'h0, 4'hF, {12'h000, st});
	endtask : chk_status
	task automatic summarize();
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		#100000;
		failures++;
		$display("wrong value at %0t: run hung", $time);
		summarize();
	end
	initial begin
		rel = 1'b0;
		arst_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'h0;
		drive(32'h04000001);
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		rnd(20);
		wb(1'b0, lbt_pkg::CTRL_OFS, 32'h0, 4'hF, 32'h0);
		wb(1'b1, 4'h8, 32'hFFFFFFFF, 4'hF, 32'h0);
		wb(1'b0, 4'h8, 32'h0, 4'hF, 32'h0);
		chk_status();
		wb(1'b1, lbt_pkg::CTRL_OFS, 32'h1, 4'h1, 32'h0);
		rel = 1'b1;
		wb(1'b1, lbt_pkg::CTRL_OFS, 32'h0, 4'hE, 32'h0);
		wb(1'b0, lbt_pkg::CTRL_OFS, 32'h0, 4'hF, 32'h1);
		repeat (60) begin
			rnd(12);
			chk_status();
		end
		summarize();
	end
endmodule : tb
